// File: common/xid_pkg.sv
package xid_pkg;

	// widths of the core datapath
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int PC_W = 21;
	localparam int BANK_W = 4;
	localparam int APB_AW = 8;
	localparam int NUM_PTR = 3;

	// register offsets, byte addresses on the bus
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] REG_ACCUM = 8'h04;
	localparam logic [APB_AW-1:0] REG_BANK = 8'h08;
	localparam logic [APB_AW-1:0] REG_PTR0 = 8'h0c;
	localparam logic [APB_AW-1:0] REG_PTR1 = 8'h10;
	localparam logic [APB_AW-1:0] REG_PTR2 = 8'h14;
	localparam logic [APB_AW-1:0] REG_LATCH = 8'h18;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h1c;

	// field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int LATCH_UPPER_LSB = 8;
	localparam int STAT_Z_BIT = 0;
	localparam int STAT_N_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_WORD2_BIT = 3;

	// reset values; an unprogrammed part has the extension on
	localparam logic CTRL_EXT_RST = 1'b1;
	localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
	localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;

	// opcode patterns
	localparam logic [5:0] OPC_XOR = 6'h06;
	localparam logic [3:0] OPC_EXT = 4'he;
	localparam logic [3:0] SUB_ADDP = 4'h8;
	localparam logic [3:0] SUB_SUBP = 4'h9;
	localparam logic [3:0] SUB_PUSH = 4'ha;
	localparam logic [3:0] SUB_MOVS = 4'hb;
	localparam logic [15:0] OPC_CALL_THROUGH_ACCUMULATOR = 16'h0014;
	localparam logic [3:0] WORD2_PFX = 4'hf;
	localparam logic [1:0] PTR_STACK = 2'h3;
	localparam int STACK_IDX = 2;

	// addressing constants
	localparam logic [DATA_W-1:0] INDEX_LIMIT = 8'h5f;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	// quarter phases of one instruction cycle, one core clock each
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_Q1 = 5'b00010,
		ST_Q2 = 5'b00100,
		ST_Q3 = 5'b01000,
		ST_Q4 = 5'b10000
	} xid_state_t;

	// request to the data memory
	typedef struct packed {
		logic re;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} xid_mem_req_t;

	// request to the return stack and program counter
	typedef struct packed {
		logic push;
		logic pop;
		logic [PC_W-1:0] pushData;
		logic pcLoad;
		logic [PC_W-1:0] pcValue;
	} xid_flow_t;

endpackage : xid_pkg

// File: hw/xid_addr_resolve.sv
`timescale 1ns/100ps
`default_nettype none
module xid_addr_resolve import xid_pkg::*; (
	// instruction fields
	input wire logic [DATA_W-1:0] fileAddr,
	input wire logic bankBit,
	// core state
	input wire logic [BANK_W-1:0] bankReg,
	input wire logic extEnable,
	input wire logic [ADDR_W-1:0] stackPtr,
	// resolved address
	output logic [ADDR_W-1:0] dataAddr,
	output logic indexed
);

	// bank bit picks banked, indexed or access bank
	always_comb begin
		indexed = ~bankBit & extEnable & (fileAddr <= INDEX_LIMIT);
		if (bankBit) begin
			dataAddr = {bankReg, fileAddr};
		end else if (indexed) begin
			dataAddr = stackPtr + {4'h0, fileAddr};
		end else if (fileAddr <= INDEX_LIMIT) begin
			dataAddr = {ACCESS_LOW_BANK, fileAddr};
		end else begin
			dataAddr = {ACCESS_HIGH_BANK, fileAddr};
		end
	end

endmodule : xid_addr_resolve
`default_nettype wire

// File: hw/xid_apb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module xid_apb_slave import xid_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// bus side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// register file side
	input wire logic [31:0] readData,
	input wire logic addrHit,
	output logic wrEn
);

	// zero wait state: answer is ready in the first access cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addrHit;
			if (psel & ~penable) begin
				prdata <= (addrHit & ~pwrite) ? readData : 32'h00000000;
			end
		end
	end

	// write lands on the completing edge only, never on an error
	assign wrEn = psel & penable & pready & pwrite & ~pslverr & ce;

endmodule : xid_apb_slave
`default_nettype wire

// File: hw/xid_core.sv
// Overview of operation
// - xor-with-file decoded from upper six opcode bits
// - destination bit zero writes accumulator, one writes file
// - bank bit picks access bank or banked address
// - extension with bank zero, low addresses are indexed
// - xor one cycle, read Q2, write Q4, N Z
// - extension on at reset, fuse bit disables it
// - eight extension ops, none touches status flags
// - add/subtract literal to pointer, one cycle
// - pointer select three adjusts stack pointer, returns
// - return variants load PC from stack top, nop
// - call through accumulator fixed opcode, two cycles
// - call pushes PC+2, loads PC from latches and accumulator
// - indexed moves are two-word, two-cycle instructions
// - push literal stores at stack pointer, decrements
`timescale 1ns/100ps
`default_nettype none
module xid_core import xid_pkg::*; (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// register bus
	input wire logic [APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction fetch
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	output logic instrReady,
	// data memory
	output xid_mem_req_t memReq,
	input wire logic [DATA_W-1:0] memRdData,
	// return stack and program counter
	input wire logic [PC_W-1:0] pcCurrent,
	input wire logic [PC_W-1:0] returnStackTop,
	output xid_flow_t flow
);

	xid_state_t state_ff;
	logic [15:0] instr_ff;
	logic [15:0] word2_ff;
	logic cyc2_ff;
	logic wantWord2_ff;
	logic [DATA_W-1:0] result_ff;
	logic [DATA_W-1:0] hold_ff;
	logic extEn_ff;
	logic [DATA_W-1:0] accum_ff;
	logic [BANK_W-1:0] bank_ff;
	logic [ADDR_W-1:0] ptr_ff [0:NUM_PTR-1];
	logic [DATA_W-1:0] latHigh_ff;
	logic [4:0] latUpper_ff;
	logic flagN_ff;
	logic flagZ_ff;

	// field views of the captured words
	logic [3:0] opTop;
	logic [3:0] opSub;
	logic [1:0] ptrSel;
	logic [ADDR_W-1:0] lit6;
	logic [ADDR_W-1:0] srcOffset;
	logic [ADDR_W-1:0] dstOffset;
	assign opTop = instr_ff[15:12];
	assign opSub = instr_ff[11:8];
	assign ptrSel = instr_ff[7:6];
	assign lit6 = {6'h00, instr_ff[5:0]};
	assign srcOffset = {5'h00, instr_ff[6:0]};
	assign dstOffset = {5'h00, word2_ff[6:0]};

	// decode; every extension op is gated by the fuse
	logic isXor;
	logic extGrp;
	logic isPtrAdj;
	logic isUlnk;
	logic isPush;
	logic isMovs;
	logic isCallw;
	logic twoCycle;
	logic word2Ok;
	assign isXor = (instr_ff[15:10] == OPC_XOR);
	assign extGrp = extEn_ff & (opTop == OPC_EXT);
	assign isPtrAdj = extGrp & ((opSub == SUB_ADDP) | (opSub == SUB_SUBP));
	assign isUlnk = isPtrAdj & (ptrSel == PTR_STACK);
	assign isPush = extGrp & (opSub == SUB_PUSH);
	assign isMovs = extGrp & (opSub == SUB_MOVS);
	assign isCallw = extEn_ff & (instr_ff == OPC_CALL_THROUGH_ACCUMULATOR);
	assign twoCycle = isUlnk | isCallw | isMovs;
	assign word2Ok = (word2_ff[15:12] == WORD2_PFX);

	// pointer arithmetic; select three means the stack pointer
	logic [1:0] adjIdx;
	logic [ADDR_W-1:0] adjSum;
	assign adjIdx = isUlnk ? 2'(STACK_IDX) : ptrSel;
	always_comb begin
		if (opSub == SUB_SUBP) begin
			adjSum = ptr_ff[adjIdx] - lit6;
		end else begin
			adjSum = ptr_ff[adjIdx] + lit6;
		end
	end

	// file address resolution for the xor instruction
	logic [ADDR_W-1:0] xorAddr;
	xid_addr_resolve uResolve (
		.fileAddr(instr_ff[7:0]),
		.bankBit(instr_ff[8]),
		.bankReg(bank_ff),
		.extEnable(extEn_ff),
		.stackPtr(ptr_ff[STACK_IDX]),
		.dataAddr(xorAddr),
		.indexed()
	);

	// xor result straight from the memory read
	logic [DATA_W-1:0] xorVal;
	assign xorVal = accum_ff ^ memRdData;

	// commit strobe at the close of the first cycle's fourth quarter
	logic commit;
	assign commit = (state_ff == ST_Q4) & ~cyc2_ff;

	// register bus
	logic wrEn;
	logic addrHit;
	logic [31:0] readData;
	xid_apb_slave uApb (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.readData(readData),
		.addrHit(addrHit),
		.wrEn(wrEn)
	);

	// read mux; status is read only, writes to it are dropped
	always_comb begin
		addrHit = 1'b1;
		readData = 32'h00000000;
		case (paddr)
			REG_CTRL: readData[CTRL_EXT_BIT] = extEn_ff;
			REG_ACCUM: readData[DATA_W-1:0] = accum_ff;
			REG_BANK: readData[BANK_W-1:0] = bank_ff;
			REG_PTR0: readData[ADDR_W-1:0] = ptr_ff[0];
			REG_PTR1: readData[ADDR_W-1:0] = ptr_ff[1];
			REG_PTR2: readData[ADDR_W-1:0] = ptr_ff[2];
			REG_LATCH: readData[12:0] = {latUpper_ff, latHigh_ff};
			REG_STATUS: begin
				readData[STAT_Z_BIT] = flagZ_ff;
				readData[STAT_N_BIT] = flagN_ff;
				readData[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
				readData[STAT_WORD2_BIT] = wantWord2_ff;
			end
			default: addrHit = 1'b0;
		endcase
	end

	// quarter sequencer and instruction capture
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			instr_ff <= 16'h0000;
			word2_ff <= 16'h0000;
			cyc2_ff <= 1'b0;
			wantWord2_ff <= 1'b0;
			instrReady <= 1'b1;
		end else if (ce) begin
			case (state_ff)
				ST_IDLE: begin
					if (instrValid & instrReady) begin
						if (wantWord2_ff) begin
							word2_ff <= instrWord;
							cyc2_ff <= 1'b1;
						end else begin
							instr_ff <= instrWord;
							cyc2_ff <= 1'b0;
						end
						instrReady <= 1'b0;
						state_ff <= ST_Q1;
					end
				end
				ST_Q1: state_ff <= ST_Q2;
				ST_Q2: state_ff <= ST_Q3;
				ST_Q3: state_ff <= ST_Q4;
				ST_Q4: begin
					if (~cyc2_ff & isMovs) begin
						wantWord2_ff <= 1'b1;
						instrReady <= 1'b1;
						state_ff <= ST_IDLE;
					end else if (~cyc2_ff & twoCycle) begin
						cyc2_ff <= 1'b1;
						state_ff <= ST_Q1;
					end else begin
						wantWord2_ff <= 1'b0;
						instrReady <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// data memory: read held through Q2, write held through Q4
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			memReq <= '0;
		end else if (ce) begin
			memReq.re <= 1'b0;
			memReq.we <= 1'b0;
			if (state_ff == ST_Q1 && !cyc2_ff) begin
				if (isXor) begin
					memReq.re <= 1'b1;
					memReq.addr <= xorAddr;
				end else if (isMovs) begin
					memReq.re <= 1'b1;
					memReq.addr <= ptr_ff[STACK_IDX] + srcOffset;
				end
			end else if (state_ff == ST_Q3 && !cyc2_ff) begin
				if (isXor && instr_ff[9]) begin
					memReq.we <= 1'b1;
					memReq.wdata <= xorVal;
				end else if (isPush) begin
					memReq.we <= 1'b1;
					memReq.addr <= ptr_ff[STACK_IDX];
					memReq.wdata <= instr_ff[7:0];
				end
			end else if (state_ff == ST_Q3 && cyc2_ff && isMovs && word2Ok) begin
				memReq.we <= 1'b1;
				memReq.wdata <= hold_ff;
				if (instr_ff[7]) begin
					memReq.addr <= ptr_ff[STACK_IDX] + dstOffset;
				end else begin
					memReq.addr <= word2_ff[ADDR_W-1:0];
				end
			end
		end
	end

	// operand capture at the end of the process quarter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			result_ff <= 8'h00;
			hold_ff <= 8'h00;
		end else if (ce) begin
			if (state_ff == ST_Q3 && !cyc2_ff) begin
				result_ff <= xorVal;
				hold_ff <= memRdData;
			end
		end
	end

	// accumulator: the core update wins over a bus write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			accum_ff <= ACCUM_RST;
		end else if (ce) begin
			if (commit && isXor && !instr_ff[9]) begin
				accum_ff <= result_ff;
			end else if (wrEn && paddr == REG_ACCUM) begin
				accum_ff <= pwdata[DATA_W-1:0];
			end
		end
	end

	// flags change only for xor; extension ops leave them alone
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flagN_ff <= 1'b0;
			flagZ_ff <= 1'b0;
		end else if (ce) begin
			if (commit && isXor) begin
				flagN_ff <= result_ff[DATA_W-1];
				flagZ_ff <= (result_ff == 8'h00);
			end
		end
	end

	// file select pointers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_PTR; i++) begin
				ptr_ff[i] <= PTR_RST;
			end
		end else if (ce) begin
			if (commit && isPtrAdj) begin
				ptr_ff[adjIdx] <= adjSum;
			end else if (commit && isPush) begin
				ptr_ff[STACK_IDX] <= ptr_ff[STACK_IDX] - 12'h001;
			end else if (wrEn) begin
				case (paddr)
					REG_PTR0: ptr_ff[0] <= pwdata[ADDR_W-1:0];
					REG_PTR1: ptr_ff[1] <= pwdata[ADDR_W-1:0];
					REG_PTR2: ptr_ff[2] <= pwdata[ADDR_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// fuse, bank select and program counter latches, bus only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extEn_ff <= CTRL_EXT_RST;
			bank_ff <= BANK_RST;
			latHigh_ff <= 8'h00;
			latUpper_ff <= 5'h00;
		end else if (ce && wrEn) begin
			case (paddr)
				REG_CTRL: extEn_ff <= pwdata[CTRL_EXT_BIT];
				REG_BANK: bank_ff <= pwdata[BANK_W-1:0];
				REG_LATCH: begin
					latHigh_ff <= pwdata[DATA_W-1:0];
					latUpper_ff <= pwdata[LATCH_UPPER_LSB +: 5];
				end
				default: ;
			endcase
		end
	end

	// return stack and pc requests, one-cycle pulses in the fourth quarter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flow <= '0;
		end else if (ce) begin
			flow.push <= 1'b0;
			flow.pop <= 1'b0;
			flow.pcLoad <= 1'b0;
			if (state_ff == ST_Q3 && !cyc2_ff) begin
				if (isUlnk) begin
					flow.pop <= 1'b1;
					flow.pcLoad <= 1'b1;
					flow.pcValue <= returnStackTop;
				end else if (isCallw) begin
					flow.push <= 1'b1;
					flow.pushData <= pcCurrent + PC_STEP;
					flow.pcLoad <= 1'b1;
					flow.pcValue <= {latUpper_ff, latHigh_ff, accum_ff};
				end
			end
		end
	end

endmodule : xid_core
`default_nettype wire

// File: tb/xid_checker.sv
`timescale 1ns/100ps
`default_nettype none
module xid_checker import xid_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// bus and fetch
	input wire logic [APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	input wire logic instrReady,
	// memory and flow
	input wire xid_mem_req_t memReq,
	input wire logic [PC_W-1:0] pcCurrent,
	input wire logic [PC_W-1:0] returnStackTop,
	input wire xid_flow_t flow
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// fuse as last written over the bus; extension checks must know it
	logic busWr;
	logic extSeen_ff;
	assign busWr = ce && psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extSeen_ff <= CTRL_EXT_RST;
		end else if (busWr && paddr == REG_CTRL) begin
			extSeen_ff <= pwdata[CTRL_EXT_BIT];
		end
	end
	// word accepted at this edge
	sequence s_take;
		instrValid && instrReady;
	endsequence
	// read in q2, write in q4
	sequence s_read_write;
		##2 memReq.re ##2 memReq.we;
	endsequence
	a_bus_answer: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_xor_to_file: assert property (
		s_take ##0 (instrWord[15:10] == OPC_XOR && instrWord[9]) |-> s_read_write)
		else $error("xor to file missed read or write");
	a_xor_to_accum: assert property (
		s_take ##0 (instrWord[15:10] == OPC_XOR && !instrWord[9]) |-> ##4 !memReq.we)
		else $error("xor to accumulator wrote memory");
	a_xor_one_cycle: assert property (
		s_take ##0 instrWord[15:10] == OPC_XOR |=> !instrReady[*4] ##1 instrReady)
		else $error("xor not one instruction cycle");
	a_we_pulse: assert property (memReq.we |=> !memReq.we)
		else $error("write strobe longer than one cycle");
	a_ulnk_two: assert property (
		s_take ##0 (extSeen_ff && instrWord[15:9] == 7'h74 && instrWord[7:6] == PTR_STACK)
		|=> !instrReady[*8] ##1 instrReady)
		else $error("stack return form not two cycles");
	a_call_two: assert property (
		s_take ##0 (extSeen_ff && instrWord == OPC_CALL_THROUGH_ACCUMULATOR) |=> !instrReady[*8] ##1 instrReady)
		else $error("call not two cycles");
	a_call_push: assert property (
		s_take ##0 (extSeen_ff && instrWord == OPC_CALL_THROUGH_ACCUMULATOR)
		|-> ##4 flow.push && flow.pushData == pcCurrent + PC_STEP)
		else $error("call pushed wrong return address");
	a_pop_return: assert property (
		flow.pop |-> flow.pcLoad && flow.pcValue == $past(returnStackTop))
		else $error("return did not load stack top");
	a_push_lit: assert property (
		s_take ##0 (extSeen_ff && instrWord[15:8] == 8'hea) |-> ##4 memReq.we)
		else $error("push literal did not write");
	a_push_inert: assert property (
		s_take ##0 (!extSeen_ff && instrWord[15:8] == 8'hea) |-> ##4 !memReq.we)
		else $error("push literal wrote with extension off");
endmodule : xid_checker

bind xid_core xid_checker u_chk (.core_clk(core_clk), .rst(rst), .ce(ce), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .instrWord(instrWord),
	.instrValid(instrValid), .instrReady(instrReady), .memReq(memReq),
	.pcCurrent(pcCurrent), .returnStackTop(returnStackTop), .flow(flow));
`default_nettype wire

// File: tb/xid_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module xid_mem_model import xid_pkg::*; (
	// clock
	input wire logic core_clk,
	// core requests
	input wire xid_mem_req_t memReq,
	input wire xid_flow_t flow,
	// answers
	output logic [DATA_W-1:0] memRdData,
	output logic [PC_W-1:0] returnStackTop
);
	logic [DATA_W-1:0] mem [0:4095];
	logic [PC_W-1:0] stk [0:7];
	logic [2:0] depth = 3'h0;
	logic [PC_W-1:0] lastPc = 21'h0;
	initial begin
		memRdData = 8'h0;
		for (int i = 0; i < 4096; i++) mem[i] = 8'h0;
		for (int i = 0; i < 8; i++) stk[i] = 21'h0;
	end
	assign returnStackTop = stk[depth - 3'h1];
	// data valid one cycle after the strobe, then scrambled so stale reads show
	always @(posedge core_clk) begin
		memRdData <= memReq.re ? mem[memReq.addr] : ~memRdData;
		if (memReq.we) mem[memReq.addr] <= memReq.wdata;
	end
	// return stack and last loaded program counter
	always @(posedge core_clk) begin
		if (flow.push) begin
			stk[depth] <= flow.pushData;
			depth <= depth + 3'h1;
		end else if (flow.pop) depth <= depth - 3'h1;
		if (flow.pcLoad) lastPc <= flow.pcValue;
	end
endmodule : xid_mem_model
`default_nettype wire

// File: tb/test_extended_instruction_decode.sv
`timescale 1ns/100ps
`default_nettype none
module test_extended_instruction_decode import xid_pkg::*;;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic [APB_AW-1:0] paddr = 8'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] instrWord = 16'h0;
	logic instrValid = 1'h0;
	logic instrReady;
	xid_mem_req_t memReq;
	logic [DATA_W-1:0] memRdData;
	logic [PC_W-1:0] pcCurrent = 21'h000100;
	logic [PC_W-1:0] returnStackTop;
	xid_flow_t flow;
	int n_mismatch = 0;
	int checked = 0;

	initial forever #2.5 core_clk = ~core_clk;

	xid_core dut (.core_clk(core_clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .instrWord(instrWord),
		.instrValid(instrValid), .instrReady(instrReady), .memReq(memReq),
		.memRdData(memRdData), .pcCurrent(pcCurrent),
		.returnStackTop(returnStackTop), .flow(flow));
	xid_mem_model u_far (.core_clk(core_clk), .memReq(memReq), .flow(flow),
		.memRdData(memRdData), .returnStackTop(returnStackTop));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer; an idle edge after it keeps psel from a double assignment
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		chk($sformatf("reg %h", a), exp, q);
	endtask : rd

	// hand one word over, then wait until the core asks again
	task automatic exec(input logic [15:0] w);
		instrWord <= w;
		instrValid <= 1'h1;
		do @(posedge core_clk); while (instrReady !== 1'h1);
		instrValid <= 1'h0;
		do @(posedge core_clk); while (instrReady !== 1'h1);
	endtask : exec

	task automatic t_reset;
		logic [31:0] q;
		logic e;
		rd(REG_CTRL, 32'h1);
		rd(REG_ACCUM, 32'h0);
		apb(1'h0, 8'h20, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
	endtask : t_reset

	task automatic t_xor;
		wr(REG_ACCUM, 32'hb5);
		u_far.mem[12'hfaf] = 8'haf;
		exec(16'h1aaf);
		chk("file xor", 32'h1a, u_far.mem[12'hfaf]);
		rd(REG_ACCUM, 32'hb5);
		rd(REG_STATUS, 32'h0);
		wr(REG_BANK, 32'h3);
		u_far.mem[12'h312] = 8'hb5;
		exec(16'h1912);
		rd(REG_ACCUM, 32'h0);
		rd(REG_STATUS, 32'h1);
		chk("banked file", 32'hb5, u_far.mem[12'h312]);
	endtask : t_xor

	task automatic t_indexed;
		wr(REG_ACCUM, 32'hff);
		wr(REG_PTR2, 32'h100);
		u_far.mem[12'h110] = 8'h0f;
		exec(16'h1a10);
		chk("indexed xor", 32'hf0, u_far.mem[12'h110]);
		rd(REG_STATUS, 32'h2);
		wr(REG_CTRL, 32'h0);
		exec(16'h1a10);
		chk("access xor", 32'hff, u_far.mem[12'h010]);
		exec(16'hea5a);
		rd(REG_PTR2, 32'h100);
		chk("inert push", 32'h0, u_far.mem[12'h100]);
		wr(REG_CTRL, 32'h1);
	endtask : t_indexed

	task automatic t_pointers;
		wr(REG_PTR0, 32'h3ff);
		wr(REG_PTR1, 32'h0);
		exec(16'he823);
		exec(16'he941);
		rd(REG_PTR0, 32'h422);
		rd(REG_PTR1, 32'hfff);
		rd(REG_STATUS, 32'h2);
	endtask : t_pointers

	task automatic t_call_return;
		wr(REG_ACCUM, 32'h34);
		wr(REG_LATCH, 32'h122);
		exec(OPC_CALL_THROUGH_ACCUMULATOR);
		chk("call target", 32'h12234, u_far.lastPc);
		exec(OPC_CALL_THROUGH_ACCUMULATOR);
		chk("return address", 32'h102, returnStackTop);
		wr(REG_PTR2, 32'h3ff);
		exec(16'he8e3);
		chk("return target", 32'h102, u_far.lastPc);
		rd(REG_PTR2, 32'h422);
		exec(16'he9c2);
		rd(REG_PTR2, 32'h420);
	endtask : t_call_return

	task automatic t_push_move;
		exec(16'hea5a);
		chk("pushed literal", 32'h5a, u_far.mem[12'h420]);
		rd(REG_PTR2, 32'h41f);
		u_far.mem[12'h424] = 8'hc3;
		exec(16'heb05);
		rd(REG_STATUS, 32'ha);
		exec(16'hf123);
		chk("moved byte", 32'hc3, u_far.mem[12'h123]);
		exec(16'heb85);
		exec(16'hf007);
		chk("indexed move", 32'hc3, u_far.mem[12'h426]);
		u_far.mem[12'h424] = 8'h3c;
		exec(16'heb85);
		exec(16'h0007);
		chk("bad second word", 32'hc3, u_far.mem[12'h426]);
		rd(REG_STATUS, 32'h2);
	endtask : t_push_move

	task automatic close_out;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		t_reset();
		t_xor();
		t_indexed();
		t_pointers();
		t_call_return();
		t_push_move();
		close_out();
	end
endmodule : test_extended_instruction_decode
`default_nettype wire
